//--- rtl/sar_ctl_map.svh
// constants for the successive-approximation conversion control
// assumes a 200 MHz system clock; included by the package and modules
`ifndef SAR_CTL_MAP_SVH
`define SAR_CTL_MAP_SVH

`define CLK_PERIOD_NS     5
`define RESULT_BITS       10
`define RESULT_MSB        9
`define CONV_MIN_NS       15000
`define CONV_MAX_NS       40000
`define BLANK_DELAY_NS    1500
`define BLANK_MIN_NS      2000
`define DATA_VALID_NS     500
// bit trial period: 25 us typical over ten trials, 2500 ns each
`define TRIAL_NS          2500
`define TRIAL_CYCLES      ((`TRIAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_DLY_CYCLES  (`BLANK_DELAY_NS / `CLK_PERIOD_NS)
`define BLANK_MIN_CYCLES  ((`BLANK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_MIN_CYCLES   (`CONV_MIN_NS / `CLK_PERIOD_NS)
`define CONV_MAX_CYCLES   (`CONV_MAX_NS / `CLK_PERIOD_NS)
`define CNT_W             16
`define RESULT_ZERO       10'h000
`define MSB_ONEHOT        10'h200
`define CNT_ZERO          16'h0000
`define CNT_ONE           16'h0001

`endif

//--- rtl/sar_ctl_pkg.sv
// types for the successive-approximation conversion control
// assumes sar_ctl_map.svh on the include path
`include "sar_ctl_map.svh"
package sar_ctl_pkg;
  typedef logic [`RESULT_MSB:0] result_t;
  typedef logic [`CNT_W-1:0]    count_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_HALTED,
    ST_READY
  } conv_state_t;
endpackage

//--- rtl/trial_timer.sv
// trial period timer: one pulse per bit trial period
// assumes clk_sys at 200 MHz and synchronous active-low reset
`timescale 1ns/1ps
`include "sar_ctl_map.svh"
module trial_timer (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic              run,
  output logic                   tick
);
  import sar_ctl_pkg::*;

  typedef struct packed {
    count_t cnt;
  } timer_state_t;

  timer_state_t st_q;
  timer_state_t st_d;

  // -----------------------------------------------------------------
  // free-running counter, restarted whenever run is low
  // -----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (!run) begin
      st_d.cnt = `CNT_ZERO;
    end else if (st_q.cnt == count_t'(`TRIAL_CYCLES - 1)) begin
      st_d.cnt = `CNT_ZERO;
    end else begin
      st_d.cnt = st_q.cnt + `CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign tick = run && (st_q.cnt == count_t'(`TRIAL_CYCLES - 1));
endmodule

//--- rtl/sar_conv_ctl.sv
// conversion control of a 10-bit successive-approximation converter
// assumes comparator decision is synchronous to clk_sys; no bus
// Operation
// - trial bits run from msb down to lsb, one per step
// - trial bit stays set when dac sum is below the input
// - trial bit cleared when dac sum exceeds the input
// - after all trials the register holds the 10-bit result
// - result_valid_n goes low when the bit sequence finishes
// - result_valid_n low enables the three-state data outputs
// - enabled data lines follow the approximation register bits
// - raising blank/convert floats outputs and re-arms the register
// - unipolar gives straight binary, bipolar gives offset binary
// - bipolar select switches an offset term into the comparison
// - full conversion takes between 15 and 40 microseconds
// - data lines active within 500 ns of result_valid_n low
// - blank held 2 us clears a conversion and allows restart
// - blank raised mid-conversion stops it, outputs unchanged
`timescale 1ns/1ps
`include "sar_ctl_map.svh"
module sar_conv_ctl (
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  input  wire logic                blank_convert,
  input  wire logic                bipolar_sel,
  input  wire logic                comp_above,
  output logic                     offset_en,
  output sar_ctl_pkg::result_t     dac_code,
  output sar_ctl_pkg::result_t     data_out,
  output logic                     data_oe,
  output logic                     result_valid_n
);
  import sar_ctl_pkg::*;

  typedef struct packed {
    conv_state_t state;
    result_t     approximation_register;
    result_t     trial_bit;
    count_t      blank_cnt;
    count_t      conv_cnt;
    logic        out_en;
    logic        ready_n;
    logic        offset;
  } ctl_state_t;

  ctl_state_t st_q;
  ctl_state_t st_d;
  logic       tick;
  logic       run;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic count_t sat_inc(input count_t v);
    sat_inc = (v == '1) ? v : v + `CNT_ONE;
  endfunction

  // -----------------------------------------------------------------
  // trial timer
  // -----------------------------------------------------------------
  assign run = (st_q.state == ST_CONVERT) && !blank_convert;

  trial_timer u_timer (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .run     (run),
    .tick    (tick)
  );

  // -----------------------------------------------------------------
  // control sequence
  // -----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // offset current follows the static select; latched per conversion
    if (st_q.state == ST_IDLE) begin
      st_d.offset = bipolar_sel;
    end
    if (blank_convert) begin
      st_d.blank_cnt = sat_inc(st_q.blank_cnt);
    end else begin
      st_d.blank_cnt = `CNT_ZERO;
    end
    // running age of the conversion, halted cycles left out
    if (st_q.state == ST_IDLE) begin
      st_d.conv_cnt = `CNT_ZERO;
    end else if (run) begin
      st_d.conv_cnt = sat_inc(st_q.conv_cnt);
    end
    case (st_q.state)
      ST_IDLE: begin
        if (!blank_convert) begin
          // start with the msb on as the first trial
          st_d.state = ST_CONVERT;
          st_d.trial_bit = `MSB_ONEHOT;
          st_d.approximation_register = `MSB_ONEHOT;
        end
      end
      ST_CONVERT: begin
        if (blank_convert) begin
          st_d.state = ST_HALTED;
        end else if (tick) begin
          // decision sampled once per trial period
          if (comp_above) begin
            st_d.approximation_register =
              st_q.approximation_register & ~st_q.trial_bit;
          end // else bit left on
          st_d.trial_bit = st_q.trial_bit >> 1;
          st_d.approximation_register = st_d.approximation_register |
                                        (st_q.trial_bit >> 1);
          if (st_q.trial_bit[0]) begin
            // lsb decided: result complete
            st_d.state = ST_READY;
            st_d.ready_n = 1'b0;
            st_d.out_en = 1'b1;
          end
        end
      end
      ST_HALTED: begin
        // short pulse resumes; a full blank pulse clears
        if (st_q.blank_cnt >= count_t'(`BLANK_MIN_CYCLES - 1)) begin
          st_d.state = ST_IDLE;
          st_d.approximation_register = `RESULT_ZERO;
        end else if (!blank_convert) begin
          st_d.state = ST_CONVERT;
        end
      end
      ST_READY: begin
        if (blank_convert &&
            st_q.blank_cnt >= count_t'(`BLANK_DLY_CYCLES - 1)) begin
          st_d.state = ST_IDLE;
          st_d.ready_n = 1'b1;
          st_d.out_en = 1'b0;
          st_d.approximation_register = `RESULT_ZERO;
          st_d.trial_bit = `RESULT_ZERO;
        end
      end
      default: begin
        st_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q.state <= ST_IDLE;
      st_q.approximation_register <= `RESULT_ZERO;
      st_q.trial_bit <= `RESULT_ZERO;
      st_q.blank_cnt <= `CNT_ZERO;
      st_q.conv_cnt <= `CNT_ZERO;
      st_q.out_en <= 1'b0;
      st_q.ready_n <= 1'b1;
      st_q.offset <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  // code is plain binary in both modes; the offset term makes it offset
  // binary in bipolar mode, so no recoding is needed here
  assign data_out = st_q.approximation_register;
  assign data_oe = st_q.out_en;
  assign result_valid_n = st_q.ready_n;
  assign dac_code = st_q.approximation_register;
  assign offset_en = st_q.offset;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_oe_follows_ready: assert property (
    data_oe == !result_valid_n)
    else $error("output enable not tied to result valid");

  a_ready_on_lsb: assert property (
    clk_en && st_q.state == ST_CONVERT && !blank_convert && tick &&
    st_q.trial_bit[0] |=> !result_valid_n)
    else $error("result valid missing after lsb trial");

  a_halt_holds_out: assert property (
    st_q.state == ST_CONVERT && blank_convert |=> $stable(result_valid_n)
    && $stable(data_out))
    else $error("halted conversion changed outputs");

  a_bit_cleared: assert property (
    clk_en && run && tick && comp_above |=>
    ((data_out & $past(st_q.trial_bit)) == `RESULT_ZERO))
    else $error("trial bit not cleared on comparator high");

  a_bit_kept: assert property (
    clk_en && run && tick && !comp_above |=>
    ((data_out & $past(st_q.trial_bit)) != `RESULT_ZERO))
    else $error("trial bit lost on comparator low");

  a_one_trial_bit: assert property (
    st_q.state == ST_CONVERT |-> $onehot(st_q.trial_bit))
    else $error("trial bit not one-hot");

  a_start_msb: assert property (
    clk_en && st_q.state == ST_IDLE && !blank_convert |=>
    st_q.trial_bit == `MSB_ONEHOT)
    else $error("conversion did not start at msb");

  a_ready_stays: assert property (
    st_q.state == ST_READY && !blank_convert |=> !result_valid_n)
    else $error("result valid dropped without blank");

  a_release_float: assert property (
    !result_valid_n ##1 result_valid_n |-> !data_oe &&
    $past(blank_convert))
    else $error("release without blank or outputs still driven");

  a_offset_static: assert property (
    st_q.state != ST_IDLE |=> $stable(offset_en))
    else $error("offset changed mid-conversion");

  a_idle_quiet: assert property (
    st_q.state == ST_IDLE |-> result_valid_n && !data_oe)
    else $error("idle state with outputs driven");

  a_rearm_zero: assert property (
    st_q.state == ST_IDLE |-> dac_code == `RESULT_ZERO)
    else $error("register not re-armed in idle");

  a_idle_waits: assert property (
    st_q.state == ST_IDLE && blank_convert |=> st_q.state == ST_IDLE)
    else $error("conversion started while blanked");

  a_oe_only_ready: assert property (
    st_q.state != ST_READY |-> !data_oe)
    else $error("data lines driven outside ready state");

  a_result_complete: assert property (
    st_q.state == ST_READY |-> st_q.trial_bit == `RESULT_ZERO)
    else $error("result flagged before all trials");

  a_data_with_ready: assert property (
    $fell(result_valid_n) |-> data_oe)
    else $error("data lines late after result valid");

  a_offset_latched: assert property (
    clk_en && st_q.state == ST_IDLE |=> offset_en == $past(bipolar_sel))
    else $error("offset select not latched in idle");

  // -----------------------------------------------------------------
  // assertions: timing window and blank handling
  // -----------------------------------------------------------------
  // age counts running cycles only, so a halt does not eat the window
  a_conv_window: assert property (
    clk_en && run && tick && st_q.trial_bit[0] |->
    st_q.conv_cnt >= count_t'(`CONV_MIN_CYCLES - 1) &&
    st_q.conv_cnt <= count_t'(`CONV_MAX_CYCLES - 1))
    else $error("conversion time outside window");

  a_trial_on_tick: assert property (
    st_q.state == ST_CONVERT && !tick |=> $stable(st_q.trial_bit))
    else $error("trial bit moved between timer ticks");

  a_no_early_release: assert property (
    st_q.state == ST_READY &&
    st_q.blank_cnt < count_t'(`BLANK_DLY_CYCLES - 1) |=>
    !result_valid_n && data_oe)
    else $error("result released before blank delay");

  a_release_on_time: assert property (
    clk_en && st_q.state == ST_READY && blank_convert &&
    st_q.blank_cnt == count_t'(`BLANK_DLY_CYCLES - 1) |=>
    result_valid_n && !data_oe && data_out == `RESULT_ZERO)
    else $error("result not released after blank delay");

  a_halt_frozen: assert property (
    st_q.state == ST_HALTED &&
    st_q.blank_cnt < count_t'(`BLANK_MIN_CYCLES - 1) |=>
    $stable(dac_code) && $stable(result_valid_n))
    else $error("halted conversion moved");

  a_full_blank_clears: assert property (
    clk_en && st_q.state == ST_HALTED &&
    st_q.blank_cnt >= count_t'(`BLANK_MIN_CYCLES - 1) |=>
    st_q.state == ST_IDLE && dac_code == `RESULT_ZERO)
    else $error("full blank pulse did not clear");

  // enable low holds every field; the timer freezes on the same input
  a_freeze_state: assert property (
    !clk_en |=> $stable(st_q))
    else $error("state moved with clock enable low");

  c_full_conv: cover property (
    st_q.state == ST_CONVERT ##1 st_q.state == ST_READY);
  c_halt_resume: cover property (
    st_q.state == ST_HALTED ##1 st_q.state == ST_CONVERT);
  c_halt_clear: cover property (
    st_q.state == ST_HALTED ##1 st_q.state == ST_IDLE);
  c_bipolar: cover property (
    offset_en && !result_valid_n);
  c_freeze: cover property (!clk_en && st_q.state == ST_CONVERT);
endmodule

//--- dv/comparator_model.sv
// comparator in front of the conversion control, digital stand-in
// assumes input level in lsb units; bench keeps it in range
`timescale 1ns/1ps
module comparator_model (
  offset_en,
  dac_code,
  level,
  comp_above
);
  import sar_ctl_pkg::*;
  input  wire logic               offset_en;
  input  wire sar_ctl_pkg::result_t dac_code;
  input  wire logic signed [11:0] level;
  output logic                    comp_above;
  // ----------------------------------------
  // decision
  // ----------------------------------------
  logic signed [11:0] eff;
  // offset lifts the input by half scale, giving offset binary
  assign eff = level + (offset_en ? 12'sh200 : 12'sh000);
  // equal sum counts as not above, so the bit stays set
  assign comp_above = $signed({2'b00, dac_code}) > eff;
endmodule

//--- dv/testbench.sv
// self-checking bench for the conversion control
// assumes comparator_model beside the design, single 200 MHz clock
`timescale 1ns/1ps
module testbench;
  import sar_ctl_pkg::*;
  logic               clk_sys = 1'b0;
  logic               reset_n, clk_en, blank_convert, bipolar_sel;
  logic               comp_above, offset_en, data_oe, result_valid_n;
  result_t            dac_code, data_out;
  logic signed [11:0] level;
  int                 n_mismatch = 0;
  int                 checks_done = 0;
  always #2.5 clk_sys = ~clk_sys;
  sar_conv_ctl DUT (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .blank_convert(blank_convert), .bipolar_sel(bipolar_sel),
    .comp_above(comp_above), .offset_en(offset_en), .dac_code(dac_code),
    .data_out(data_out), .data_oe(data_oe),
    .result_valid_n(result_valid_n));
  comparator_model far_side (.offset_en(offset_en), .dac_code(dac_code),
    .level(level), .comp_above(comp_above));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // bounded wait for the ready line, output enable tracked each cycle
  task automatic wait_rdy(logic lvl, int bound, output int n);
    n = 0;
    while (result_valid_n !== lvl && n < bound) begin
      check("oe vs ready", data_oe, !result_valid_n);
      step;
      n++;
    end
    if (n >= bound) begin
      n_mismatch++;
      $display("BAD ready wait expected %0h seen timeout", lvl);
      close_out;
    end
  endtask
  // raise blank, expect release after 300 cycles, then finish 750 ns
  task automatic release_blank;
    int n;
    blank_convert = 1'b1;
    wait_rdy(1'b1, 600, n);
    check("blank delay", n >= 298 && n <= 302, 1'b1);
    check("oe off", data_oe, 1'b0);
    check("rearm", dac_code, 10'h000);
    repeat (150) step;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic convert(logic signed [11:0] lv, logic bip);
    int n;
    result_t exp;
    level = lv;
    bipolar_sel = bip;
    step;
    blank_convert = 1'b0;
    step;
    check("first trial", dac_code, 10'h200);
    check("offset term", offset_en, bip);
    wait_rdy(1'b0, 9000, n);
    exp = 10'(lv + (bip ? 12'sh200 : 12'sh000));
    check("conv time", n >= 3000 && n <= 8000, 1'b1);
    check("conv cycles", 16'(n), 16'h1388);
    check("result", data_out, exp);
    check("data on", data_oe, 1'b1);
    release_blank;
  endtask
  // short blank in mid-run halts without touching the outputs
  task automatic halt_mid;
    int n;
    result_t held;
    level = 12'sh2BC;
    bipolar_sel = 1'b0;
    step;
    blank_convert = 1'b0;
    repeat (1200) step;
    blank_convert = 1'b1;
    step;
    held = dac_code;
    repeat (100) step;
    check("halt code", dac_code, held);
    check("halt ready", result_valid_n, 1'b1);
    check("halt oe", data_oe, 1'b0);
    blank_convert = 1'b0;
    wait_rdy(1'b0, 9000, n);
    check("halt time", 16'(n), 16'hFA1);
    check("halt result", data_out, 10'h2BC);
    release_blank;
  endtask
  // long blank in mid-run clears and a fresh conversion follows
  task automatic restart_mid;
    int n;
    level = 12'sh12C;
    step;
    blank_convert = 1'b0;
    repeat (2000) step;
    blank_convert = 1'b1;
    repeat (450) step;
    check("cleared", dac_code, 10'h000);
    check("clear ready", result_valid_n, 1'b1);
    blank_convert = 1'b0;
    wait_rdy(1'b0, 9000, n);
    check("restart time", 16'(n), 16'h1389);
    check("restart result", data_out, 10'h12C);
    release_blank;
  endtask
  // clock enable low in mid-run freezes trials and timer alike
  task automatic freeze_mid;
    int n;
    result_t held;
    level = 12'sh155;
    bipolar_sel = 1'b0;
    step;
    blank_convert = 1'b0;
    repeat (1200) step;
    clk_en = 1'b0;
    held = dac_code;
    repeat (1000) step;
    check("freeze code", dac_code, held);
    check("freeze ready", result_valid_n, 1'b1);
    clk_en = 1'b1;
    wait_rdy(1'b0, 9000, n);
    check("freeze time", 16'(n), 16'hED9);
    check("freeze result", data_out, 10'h155);
    release_blank;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    blank_convert = 1'b1;
    bipolar_sel = 1'b0;
    level = 12'sh000;
    repeat (5) step;
    reset_n = 1'b1;
    step;
    check("reset ready", result_valid_n, 1'b1);
    convert(12'sh000, 1'b0);
    convert(12'sh3FF, 1'b0);
    convert(12'sh155, 1'b0);
    convert(12'sh2AA, 1'b0);
    convert(-12'sh200, 1'b1);
    convert(12'sh000, 1'b1);
    convert(12'sh1FF, 1'b1);
    halt_mid;
    restart_mid;
    freeze_mid;
    close_out;
  end
endmodule
